// file: verilog/dsp_lpm_pkg.sv
/*
  Constants for the downstream port link power manager: register map,
  link state codes, timer units and the state encoding.
  Assumes a 200 MHz system clock.
*/
package dsp_lpm_pkg;
  localparam int CLK_PERIOD_NS = 5;
  localparam int U1_UNIT_NS = 1000;
  localparam int U2_UNIT_NS = 256000;
  localparam int U1_UNIT_CYC = U1_UNIT_NS / CLK_PERIOD_NS;
  localparam int U2_UNIT_CYC = U2_UNIT_NS / CLK_PERIOD_NS;

  localparam logic [7:0] OFS_U1_TIMEOUT = 8'h00;
  localparam logic [7:0] OFS_U2_TIMEOUT = 8'h04;
  localparam logic [7:0] OFS_LINK_REQ = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] OFS_UP_CFG = 8'h10;

  localparam logic [7:0] TO_ZERO = 8'h00;
  localparam logic [7:0] TO_NEVER = 8'hFF;

  localparam logic [1:0] LS_U0 = 2'h0;
  localparam logic [1:0] LS_U1 = 2'h1;
  localparam logic [1:0] LS_U2 = 2'h2;
  localparam logic [1:0] LS_U3 = 2'h3;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [5:0] {
    PM_U0 = 6'h01,
    PM_TRY_U1 = 6'h02,
    PM_TRY_U2 = 6'h04,
    PM_IN_U1 = 6'h08,
    PM_IN_U2 = 6'h10,
    PM_IN_U3 = 6'h20
  } pm_e;
endpackage

// file: verilog/hub_dsport_lpm.sv
/*
  Link power management for one downstream facing hub port, with an
  AXI4-Lite register slave. Assumes the link layer, the other ports and
  the upstream port run on sys_clk_i and give one-cycle event pulses.
*/
// Notes on behaviour
// - Timeout writes and non-timestamp packets clear timers.
// - U1 timer never early, at most 1 us late.
// - U2 timer never early, at most 500 us late.
// - Both timeouts zero: reject partner, never initiate.
// - Only U1 timeout set: reject U2, accept U1.
// - U1 timeout FF: no own U1 entry.
// - U1 timer reaching timeout starts U1 entry.
// - Only U2 timeout set: reject U1, accept U2.
// - U2 timeout FF: no own U2 entry.
// - U1 zero: U2 timer moves U0 to U2.
// - Both set: clear timers, accept unless queued.
// - U0 request, exit or rejection returns to U0.
// - Wake from U3 on partner wake, held for upstream wake if upstream in U3.
// - U1 attempt; request-started attempts keep retrying.
// - U2 attempt; request-started attempts keep retrying.
// - All ports U1 or deeper: upstream to U1.
// - In U1, U2 timer may move to U2.
// - Leaving U1: wake upstream unless already U0.
// - All ports U2 or deeper: upstream U2 else U1.
// - Leaving U2: wake upstream from U2 or U1.
// - Entering U3: upstream as on U2 entry.
// - Drop packets for U3 port, still acknowledge header.
`timescale 1ns/1ps
module hub_dsport_lpm
  import dsp_lpm_pkg::*;
#(
  parameter int U2_UNIT_CYCLES = U2_UNIT_CYC
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic awvalid_i,
  output logic awready_o,
  input wire logic [7:0] awaddr_i,
  input wire logic wvalid_i,
  output logic wready_o,
  input wire logic [31:0] wdata_i,
  input wire logic [3:0] wstrb_i,
  output logic bvalid_o,
  input wire logic bready_i,
  output logic [1:0] bresp_o,
  input wire logic arvalid_i,
  output logic arready_o,
  input wire logic [7:0] araddr_i,
  output logic rvalid_o,
  input wire logic rready_i,
  output logic [31:0] rdata_o,
  output logic [1:0] rresp_o,
  input wire logic pkt_i,
  input wire logic pkt_itp_i,
  input wire logic queued_i,
  input wire logic ptr_u1_req_i,
  input wire logic ptr_u2_req_i,
  input wire logic lnk_reject_i,
  input wire logic lnk_u1_done_i,
  input wire logic lnk_u2_done_i,
  input wire logic lnk_u3_done_i,
  input wire logic lnk_u0_done_i,
  input wire logic ptr_exit_i,
  input wire logic ptr_wake_i,
  input wire logic us_wake_i,
  input wire logic pkt_to_port_i,
  input wire logic [1:0] others_min_i,
  input wire logic [1:0] us_state_i,
  output logic go_u0_o,
  output logic go_u1_o,
  output logic go_u2_o,
  output logic accept_o,
  output logic reject_o,
  output logic us_go_u0_o,
  output logic us_go_u1_o,
  output logic us_go_u2_o,
  output logic drop_o,
  output logic hdr_ack_o
);
  localparam logic [7:0] U1_LAST = 8'(U1_UNIT_CYC - 1);
  localparam logic [15:0] U2_LAST = 16'(U2_UNIT_CYCLES - 1);

  typedef struct packed {
    pm_e st;
    logic retry;
    logic woke;
    logic [7:0] u1_to;
    logic [7:0] u2_to;
    logic [7:0] u1_cnt;
    logic [7:0] u2_cnt;
    logic [7:0] u1_pre;
    logic [15:0] u2_pre;
    logic [1:0] up_en;
    logic go_u0;
    logic go_u1;
    logic go_u2;
    logic acc;
    logic rej;
    logic us_u0;
    logic us_u1;
    logic us_u2;
    logic drop;
    logic hack;
    logic awready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } lpm_s;

  lpm_s s_r;
  lpm_s s_nxt;
  logic ls_wr;
  logic [1:0] ls_val;
  logic clr;
  logic ent_u1;
  logic ent_u2;
  logic ent_u3;
  logic leave;
  logic wr_take;
  logic rd_take;

  always_comb begin
    s_nxt = s_r;
    ls_wr = 1'b0;
    ls_val = wdata_i[1:0];
    clr = 1'b0;
    ent_u1 = 1'b0;
    ent_u2 = 1'b0;
    ent_u3 = 1'b0;
    leave = 1'b0;
    s_nxt.go_u0 = 1'b0;
    s_nxt.go_u1 = 1'b0;
    s_nxt.go_u2 = 1'b0;
    s_nxt.acc = 1'b0;
    s_nxt.rej = 1'b0;
    s_nxt.us_u0 = 1'b0;
    s_nxt.us_u1 = 1'b0;
    s_nxt.us_u2 = 1'b0;
    s_nxt.drop = 1'b0;
    s_nxt.hack = 1'b0;
    s_nxt.awready = 1'b0;
    s_nxt.arready = 1'b0;
    // Write: address and data are taken together in one cycle.
    wr_take = awvalid_i && wvalid_i && !s_r.awready && !s_r.bvalid;
    if (s_r.bvalid && bready_i) s_nxt.bvalid = 1'b0;
    if (wr_take) begin
      s_nxt.awready = 1'b1;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = RESP_OKAY;
      case (awaddr_i)
        OFS_U1_TIMEOUT: begin
          if (wstrb_i[0]) s_nxt.u1_to = wdata_i[7:0];
          clr = 1'b1;
        end
        OFS_U2_TIMEOUT: begin
          if (wstrb_i[0]) s_nxt.u2_to = wdata_i[7:0];
          clr = 1'b1;
        end
        OFS_LINK_REQ: begin
          ls_wr = wstrb_i[0] && (wdata_i[1:0] != LS_U3);
        end
        OFS_UP_CFG: begin
          if (wstrb_i[0]) s_nxt.up_en = wdata_i[1:0];
        end
        OFS_STATUS: begin end
        default: s_nxt.bresp = RESP_SLVERR;
      endcase
    end
    // Read: one word per request, held until rready.
    rd_take = arvalid_i && !s_r.arready && !s_r.rvalid;
    if (s_r.rvalid && rready_i) s_nxt.rvalid = 1'b0;
    if (rd_take) begin
      s_nxt.arready = 1'b1;
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp = RESP_OKAY;
      s_nxt.rdata = 32'h0000_0000;
      case (araddr_i)
        OFS_U1_TIMEOUT: s_nxt.rdata[7:0] = s_r.u1_to;
        OFS_U2_TIMEOUT: s_nxt.rdata[7:0] = s_r.u2_to;
        OFS_LINK_REQ: s_nxt.rdata = 32'h0000_0000;
        OFS_STATUS: s_nxt.rdata[7:0] = {s_r.woke, s_r.retry, s_r.st};
        OFS_UP_CFG: s_nxt.rdata[1:0] = s_r.up_en;
        default: s_nxt.rresp = RESP_SLVERR;
      endcase
    end
    if (pkt_i && !pkt_itp_i) clr = 1'b1;
    // Link power state sequencing.
    case (s_r.st)
      PM_U0: begin
        if (ls_wr && ls_val == LS_U1) begin
          s_nxt.go_u1 = 1'b1;
          s_nxt.retry = 1'b1;
          s_nxt.st = PM_TRY_U1;
        end else if (ls_wr && ls_val == LS_U2) begin
          s_nxt.go_u2 = 1'b1;
          s_nxt.retry = 1'b1;
          s_nxt.st = PM_TRY_U2;
        end else if (ptr_u1_req_i) begin
          if (s_r.u1_to != TO_ZERO && !queued_i) begin
            s_nxt.acc = 1'b1;
            s_nxt.retry = 1'b0;
            s_nxt.st = PM_TRY_U1;
          end else begin
            s_nxt.rej = 1'b1;
          end
        end else if (ptr_u2_req_i) begin
          if (s_r.u2_to != TO_ZERO && !queued_i) begin
            s_nxt.acc = 1'b1;
            s_nxt.retry = 1'b0;
            s_nxt.st = PM_TRY_U2;
          end else begin
            s_nxt.rej = 1'b1;
          end
        end else if (s_r.u1_to != TO_ZERO && s_r.u1_to != TO_NEVER && s_r.u1_cnt >= s_r.u1_to) begin
          s_nxt.go_u1 = 1'b1;
          s_nxt.retry = 1'b0;
          s_nxt.st = PM_TRY_U1;
        end else if (s_r.u1_to == TO_ZERO && s_r.u2_to != TO_ZERO && s_r.u2_to != TO_NEVER
                     && s_r.u2_cnt >= s_r.u2_to) begin
          s_nxt.go_u2 = 1'b1;
          s_nxt.retry = 1'b0;
          s_nxt.st = PM_TRY_U2;
        end
      end
      PM_TRY_U1: begin
        if (lnk_u1_done_i) begin
          s_nxt.st = PM_IN_U1;
          ent_u1 = 1'b1;
        end else if (lnk_reject_i) begin
          if (s_r.retry) s_nxt.go_u1 = 1'b1;
          else s_nxt.st = PM_U0;
        end
      end
      PM_TRY_U2: begin
        if (lnk_u2_done_i) begin
          s_nxt.st = PM_IN_U2;
          ent_u2 = 1'b1;
        end else if (lnk_reject_i) begin
          if (s_r.retry) s_nxt.go_u2 = 1'b1;
          else s_nxt.st = PM_U0;
        end
      end
      PM_IN_U1, PM_IN_U2: begin
        if (ptr_exit_i || pkt_to_port_i) begin
          s_nxt.go_u0 = pkt_to_port_i;
          leave = 1'b1;
        end
        if (lnk_u0_done_i) begin
          s_nxt.st = PM_U0;
        end else if (s_r.st == PM_IN_U1 && s_r.u2_to != TO_ZERO && s_r.u2_to != TO_NEVER
                     && s_r.u2_cnt >= s_r.u2_to && !leave) begin
          s_nxt.go_u2 = 1'b1;
          s_nxt.retry = 1'b0;
          s_nxt.st = PM_TRY_U2;
        end
      end
      PM_IN_U3: begin
        if (ptr_wake_i && us_state_i == LS_U3) s_nxt.woke = 1'b1;
        if ((ptr_wake_i && us_state_i != LS_U3) || (us_wake_i && s_r.woke)) begin
          s_nxt.go_u0 = 1'b1;
          s_nxt.woke = 1'b0;
          s_nxt.st = PM_U0;
        end
        if (pkt_to_port_i) begin
          s_nxt.drop = 1'b1;
          s_nxt.hack = 1'b1;
        end
      end
      default: s_nxt.st = PM_U0;
    endcase
    if (lnk_u3_done_i && s_r.st != PM_IN_U3) begin
      s_nxt.st = PM_IN_U3;
      s_nxt.woke = 1'b0;
      ent_u3 = 1'b1;
    end
    if (ls_wr && ls_val == LS_U0) begin
      s_nxt.go_u0 = 1'b1;
      s_nxt.go_u1 = 1'b0;
      s_nxt.go_u2 = 1'b0;
      s_nxt.retry = 1'b0;
      s_nxt.st = PM_U0;
      ent_u1 = 1'b0;
      ent_u2 = 1'b0;
      ent_u3 = 1'b0;
    end
    // Upstream link follows the shallowest downstream port.
    if (ent_u1 && others_min_i >= LS_U1 && s_r.up_en[0]) begin
      s_nxt.us_u1 = 1'b1;
    end
    if ((ent_u2 || ent_u3) && others_min_i >= LS_U2) begin
      s_nxt.us_u2 = s_r.up_en[1];
      s_nxt.us_u1 = !s_r.up_en[1] && s_r.up_en[0];
    end else if ((ent_u2 || ent_u3) && others_min_i >= LS_U1) begin
      s_nxt.us_u1 = s_r.up_en[0];
    end
    if (leave && us_state_i != LS_U0) s_nxt.us_u0 = 1'b1;
    // Timers: U1 counts microseconds in U0, U2 counts 256 us units.
    if (s_nxt.st == PM_U0 && s_r.st != PM_U0) begin
      clr = 1'b1;
    end
    if (s_r.u1_pre == U1_LAST) begin
      s_nxt.u1_pre = 8'h00;
      if (s_r.u1_cnt != TO_NEVER) begin
        s_nxt.u1_cnt = s_r.u1_cnt + 8'h01;
      end
    end else begin
      s_nxt.u1_pre = s_r.u1_pre + 8'h01;
    end
    if (s_r.u2_pre == U2_LAST) begin
      s_nxt.u2_pre = 16'h0000;
      if (s_r.u2_cnt != TO_NEVER) begin
        s_nxt.u2_cnt = s_r.u2_cnt + 8'h01;
      end
    end else begin
      s_nxt.u2_pre = s_r.u2_pre + 16'h0001;
    end
    if (clr || s_r.st != PM_U0) begin
      s_nxt.u1_pre = 8'h00;
      s_nxt.u1_cnt = 8'h00;
    end
    if (clr || ent_u1 || (s_r.st != PM_U0 && s_r.st != PM_IN_U1)) begin
      s_nxt.u2_pre = 16'h0000;
      s_nxt.u2_cnt = 8'h00;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      s_r <= '0;
      s_r.st <= PM_U0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign awready_o = s_r.awready;
  assign wready_o = s_r.awready;
  assign bvalid_o = s_r.bvalid;
  assign bresp_o = s_r.bresp;
  assign arready_o = s_r.arready;
  assign rvalid_o = s_r.rvalid;
  assign rdata_o = s_r.rdata;
  assign rresp_o = s_r.rresp;
  assign go_u0_o = s_r.go_u0;
  assign go_u1_o = s_r.go_u1;
  assign go_u2_o = s_r.go_u2;
  assign accept_o = s_r.acc;
  assign reject_o = s_r.rej;
  assign us_go_u0_o = s_r.us_u0;
  assign us_go_u1_o = s_r.us_u1;
  assign us_go_u2_o = s_r.us_u2;
  assign drop_o = s_r.drop;
  assign hdr_ack_o = s_r.hack;

  default clocking dc @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  sequence seq_req_u0;
    ls_wr && ls_val == LS_U0;
  endsequence

  sequence seq_back_in_u0;
    go_u0_o && s_r.st == PM_U0;
  endsequence

  AST_TIMER_CLEAR: assert property (pkt_i && !pkt_itp_i |=> s_r.u1_cnt == 8'h00 && s_r.u2_cnt == 8'h00)
    else $error("Timers not cleared by a packet.");
  AST_U1_NOT_EARLY: assert property (go_u1_o && !s_r.retry |->
    $past(s_r.u1_cnt) >= $past(s_r.u1_to) && $past(s_r.u1_to) != TO_NEVER)
    else $error("U1 entry started before the U1 timeout.");
  AST_U2_NOT_EARLY: assert property (go_u2_o && !s_r.retry |->
    $past(s_r.u2_cnt) >= $past(s_r.u2_to) && $past(s_r.u2_to) != TO_NEVER)
    else $error("U2 entry started before the U2 timeout.");
  AST_ZERO_REJECT: assert property (s_r.st == PM_U0 && s_r.u1_to == TO_ZERO && ptr_u1_req_i && !ls_wr
    && !lnk_u3_done_i |=> reject_o && !accept_o)
    else $error("Partner U1 request not rejected with zero timeout.");
  AST_U2_OFF_REJECT: assert property (s_r.st == PM_U0 && s_r.u2_to == TO_ZERO && ptr_u2_req_i
    && !ptr_u1_req_i && !ls_wr && !lnk_u3_done_i |=> reject_o)
    else $error("Partner U2 request not rejected with zero U2 timeout.");
  AST_REQ_U0: assert property (seq_req_u0 |=> seq_back_in_u0)
    else $error("U0 request did not return the port to U0.");
  AST_RETRY_U1: assert property (s_r.st == PM_TRY_U1 && s_r.retry && lnk_reject_i && !lnk_u1_done_i
    && !ls_wr && !lnk_u3_done_i |=> go_u1_o && s_r.st == PM_TRY_U1)
    else $error("Requested U1 attempt did not retry.");
  AST_WAKE_U3: assert property (s_r.st == PM_IN_U3 && ptr_wake_i && us_state_i != LS_U3
    |=> go_u0_o && s_r.st == PM_U0)
    else $error("Partner wake did not return the port to U0.");
  AST_DROP_U3: assert property (s_r.st == PM_IN_U3 && pkt_to_port_i |=> drop_o && hdr_ack_o)
    else $error("Packet to a U3 port not dropped and acknowledged.");
endmodule

// file: tb/link_partner_model.sv
/*
  Behavioural model of the attached link partner: answers entry and exit
  commands from the port after a fixed delay. Assumes one-cycle pulses.
*/
`timescale 1ns/1ps
module link_partner_model #(
  parameter int DLY = 3
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic go_u0_i,
  input wire logic go_u1_i,
  input wire logic go_u2_i,
  input wire logic accept_i,
  input wire logic req_u1_i,
  input wire logic req_u2_i,
  input wire logic exit_i,
  input wire logic rej_en_i,
  output logic reject_o,
  output logic u1_done_o,
  output logic u2_done_o,
  output logic u0_done_o
);
  logic [3:0] cnt_r;
  logic [1:0] what_r;
  logic [1:0] kind_r;
  logic rej_r;

  // Completes the entry the partner asked for, or the one commanded.
  always_ff @(posedge clk_i) begin
    reject_o <= 1'b0;
    u1_done_o <= 1'b0;
    u2_done_o <= 1'b0;
    u0_done_o <= 1'b0;
    if (req_u1_i) begin
      kind_r <= 2'h1;
    end
    if (req_u2_i) begin
      kind_r <= 2'h2;
    end
    if (rst_i) begin
      cnt_r <= 4'h0;
      what_r <= 2'h0;
      rej_r <= 1'b0;
    end else if (go_u0_i | go_u1_i | go_u2_i | accept_i | exit_i) begin
      cnt_r <= DLY[3:0];
      what_r <= (go_u0_i | exit_i) ? 2'h3 : go_u1_i ? 2'h1 : go_u2_i ? 2'h2 : kind_r;
      rej_r <= rej_en_i & ~accept_i;
    end else if (cnt_r != 4'h0) begin
      cnt_r <= cnt_r - 4'h1;
      if (cnt_r == 4'h1) begin
        reject_o <= rej_r && what_r != 2'h3;
        u1_done_o <= !rej_r && what_r == 2'h1;
        u2_done_o <= !rej_r && what_r == 2'h2;
        u0_done_o <= what_r == 2'h3;
      end
    end
  end
endmodule

// file: tb/tb_top.sv
/*
  Self-checking bench for the port link power manager.
  Assumes the register map and pulse timing of the design package.
*/
`timescale 1ns/1ps
module tb_top;
  import dsp_lpm_pkg::*;
  localparam int GU0 = 0, GU1 = 1, GU2 = 2, ACC = 3, REJ = 4;
  localparam int UU0 = 5, UU1 = 6, UU2 = 7, DRP = 8, ACK = 9;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic queued = 1'b0, rej_en = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [1:0] others_min = 2'h0, us_state = 2'h0;
  logic [8:0] ev = 9'h000;
  logic awready, wready, bvalid, arready, rvalid, l_rej, l_u1, l_u2, l_u0;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [9:0] outs;
  int n_errors = 0, n_compared = 0, cyc = 0;

  always #2.5 clk = ~clk;

  hub_dsport_lpm #(.U2_UNIT_CYCLES(8)) i_dut (
    .sys_clk_i(clk), .rst_i(rst), .awvalid_i(awvalid), .awready_o(awready), .awaddr_i(awaddr),
    .wvalid_i(wvalid), .wready_o(wready), .wdata_i(wdata), .wstrb_i(4'hF), .bvalid_o(bvalid),
    .bready_i(bready), .bresp_o(bresp), .arvalid_i(arvalid), .arready_o(arready),
    .araddr_i(araddr), .rvalid_o(rvalid), .rready_i(rready), .rdata_o(rdata), .rresp_o(rresp),
    .pkt_i(ev[0]), .pkt_itp_i(ev[1]), .queued_i(queued), .ptr_u1_req_i(ev[2]),
    .ptr_u2_req_i(ev[3]), .lnk_reject_i(l_rej), .lnk_u1_done_i(l_u1), .lnk_u2_done_i(l_u2),
    .lnk_u3_done_i(ev[8]), .lnk_u0_done_i(l_u0), .ptr_exit_i(ev[4]), .ptr_wake_i(ev[5]),
    .us_wake_i(ev[6]), .pkt_to_port_i(ev[7]), .others_min_i(others_min), .us_state_i(us_state),
    .go_u0_o(outs[0]), .go_u1_o(outs[1]), .go_u2_o(outs[2]), .accept_o(outs[3]),
    .reject_o(outs[4]), .us_go_u0_o(outs[5]), .us_go_u1_o(outs[6]), .us_go_u2_o(outs[7]),
    .drop_o(outs[8]), .hdr_ack_o(outs[9]));

  link_partner_model i_far (
    .clk_i(clk), .rst_i(rst), .go_u0_i(outs[0]), .go_u1_i(outs[1]), .go_u2_i(outs[2]),
    .accept_i(outs[3]), .req_u1_i(ev[2]), .req_u2_i(ev[3]), .exit_i(ev[4]), .rej_en_i(rej_en),
    .reject_o(l_rej), .u1_done_o(l_u1), .u2_done_o(l_u2), .u0_done_o(l_u0));

  task automatic print_verdict();
    $display("errors=%0d compared=%0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    n_compared++;
    if (got !== exp) begin
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      n_errors++;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int k;
    logic took;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    k = 0;
    took = 1'b0;
    do begin
      @(posedge clk);
      k++;
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      if (awready === 1'b1 && wready === 1'b1) took = 1'b1;
    end while (bvalid !== 1'b1 && k < 50);
    bready <= 1'b0;
    chk({took, bvalid, bresp}, {1'b1, 1'b1, er});
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    int k;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
      if (arready === 1'b1) begin
        arvalid <= 1'b0;
      end
    end while (rvalid !== 1'b1 && k < 50);
    rready <= 1'b0;
    chk({rvalid, rresp, rdata}, {1'b1, RESP_OKAY, exp});
  endtask

  task automatic pulse(input logic [8:0] m);
    @(posedge clk);
    ev <= m;
    @(posedge clk);
    ev <= 9'h000;
  endtask

  // Waits up to hi cycles; lo of zero means no pulse may come.
  task automatic win(input int i, input int lo, input int hi);
    int c;
    c = 0;
    do begin
      @(posedge clk);
      c++;
    end while (outs[i] !== 1'b1 && c < hi);
    chk(outs[i] === 1'b1 && c >= lo, lo != 0);
  endtask

  task automatic s_idle();
    rd(OFS_STATUS, 32'h01);
    pulse(9'h004);
    win(REJ, 1, 2);
    pulse(9'h008);
    win(REJ, 1, 2);
    win(GU1, 0, 300);
    wr(8'h14, 32'h0, RESP_SLVERR);
  endtask

  task automatic s_u1_only();
    wr(OFS_UP_CFG, 32'h3, RESP_OKAY);
    wr(OFS_U1_TIMEOUT, 32'hFF, RESP_OKAY);
    rd(OFS_U1_TIMEOUT, 32'hFF);
    pulse(9'h008);
    win(REJ, 1, 2);
    queued <= 1'b1;
    pulse(9'h004);
    win(REJ, 1, 2);
    queued <= 1'b0;
    win(GU1, 0, 700);
    others_min <= LS_U1;
    pulse(9'h004);
    win(ACC, 1, 2);
    win(UU1, 1, 10);
    us_state <= LS_U1;
    pulse(9'h010);
    win(UU0, 1, 2);
    repeat (6) @(posedge clk);
    rd(OFS_STATUS, 32'h01);
  endtask

  task automatic s_u1_timer();
    wr(OFS_U1_TIMEOUT, 32'h3, RESP_OKAY);
    repeat (300) @(posedge clk);
    pulse(9'h003);
    win(GU1, 290, 510);
    repeat (6) @(posedge clk);
    rd(OFS_STATUS, 32'h08);
    pulse(9'h010);
    repeat (6) @(posedge clk);
    pulse(9'h001);
    win(GU1, 595, 810);
    repeat (6) @(posedge clk);
    rd(OFS_STATUS, 32'h08);
    pulse(9'h010);
    repeat (6) @(posedge clk);
  endtask

  task automatic s_u2();
    others_min <= LS_U2;
    wr(OFS_U1_TIMEOUT, 32'h0, RESP_OKAY);
    wr(OFS_U2_TIMEOUT, 32'hFF, RESP_OKAY);
    pulse(9'h004);
    win(REJ, 1, 2);
    win(GU2, 0, 100);
    pulse(9'h008);
    win(ACC, 1, 2);
    win(UU2, 1, 10);
    us_state <= LS_U2;
    pulse(9'h010);
    win(UU0, 1, 2);
    repeat (6) @(posedge clk);
    wr(OFS_U2_TIMEOUT, 32'h1, RESP_OKAY);
    pulse(9'h001);
    win(GU2, 7, 20);
    repeat (6) @(posedge clk);
    pulse(9'h010);
    repeat (6) @(posedge clk);
    wr(OFS_U1_TIMEOUT, 32'hFF, RESP_OKAY);
    pulse(9'h004);
    win(ACC, 1, 2);
    win(GU2, 9, 25);
    repeat (6) @(posedge clk);
    rd(OFS_STATUS, 32'h10);
    pulse(9'h010);
    repeat (6) @(posedge clk);
  endtask

  task automatic s_req();
    rej_en <= 1'b1;
    wr(OFS_LINK_REQ, 32'h1, RESP_OKAY);
    win(GU1, 1, 20);
    rd(OFS_STATUS, 32'h42);
    wr(OFS_LINK_REQ, 32'h0, RESP_OKAY);
    wr(OFS_LINK_REQ, 32'h2, RESP_OKAY);
    win(GU2, 1, 20);
    wr(OFS_LINK_REQ, 32'h0, RESP_OKAY);
    rej_en <= 1'b0;
    repeat (8) @(posedge clk);
    rd(OFS_STATUS, 32'h01);
  endtask

  task automatic s_u3();
    us_state <= LS_U0;
    pulse(9'h100);
    win(UU2, 1, 2);
    rd(OFS_STATUS, 32'h20);
    pulse(9'h080);
    win(DRP, 1, 2);
    chk(outs[ACK], 1'b1);
    us_state <= LS_U3;
    pulse(9'h020);
    win(GU0, 0, 10);
    pulse(9'h040);
    win(GU0, 1, 2);
    us_state <= LS_U0;
    pulse(9'h100);
    pulse(9'h020);
    win(GU0, 1, 2);
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      print_verdict();
    end
  end

  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    s_idle();
    s_u1_only();
    s_u1_timer();
    s_u2();
    s_req();
    s_u3();
    print_verdict();
  end
endmodule
